/* File: src/fr_exec_pkg.sv */
package fr_exec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W    = 13;

  // ----------------------------------------------------------------
  // Operations and states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_IDLE    = 5'h00,
    OP_INC     = 5'h01,
    OP_OR      = 5'h02,
    OP_COPY    = 5'h03,
    OP_STORE   = 5'h04,
    OP_LOADLIT = 5'h05,
    OP_RETI    = 5'h06,
    OP_RETLIT  = 5'h07,
    OP_RET     = 5'h08,
    OP_RLC     = 5'h09,
    OP_RRC     = 5'h0A,
    OP_SLEEP   = 5'h0B,
    OP_SUBLIT  = 5'h0C,
    OP_SUBF    = 5'h0D,
    OP_XORLIT  = 5'h0E,
    OP_SWAP    = 5'h0F,
    OP_XORF    = 5'h10
  } op_t;

  typedef enum logic [1:0] {
    ST_EXEC  = 2'h0,
    ST_IDLE  = 2'h1,
    ST_SLEEP = 2'h3
  } state_t;

  typedef struct packed {
    op_t               op;
    logic [FADDR_W-1:0] addr;
    logic              dest;
    logic [DATA_W-1:0] lit;
  } instr_t;

  typedef struct packed {
    logic expiry;
    logic pdown;
    logic zero;
    logic hcarry;
    logic carry;
  } status_t;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_IRQCTL  = 12'h004;
  localparam logic [11:0] OFF_ACCUM   = 12'h008;
  localparam logic [11:0] OFF_STATUS  = 12'h00C;
  localparam logic [11:0] OFF_PC      = 12'h010;
  localparam logic [11:0] OFF_WDT     = 12'h014;
  localparam logic [11:0] OFF_FILE    = 12'h200;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_WAKE_BIT = 0;
  localparam int          GIE_BIT       = 7;
  localparam logic [7:0]  WDT_CLEAR     = 8'h00;
  localparam logic [7:0]  PRESC_CLEAR   = 8'h00;
  localparam status_t     STATUS_RESET  = '{expiry: 1'b1, pdown: 1'b1, zero: 1'b0,
                                            hcarry: 1'b0, carry: 1'b0};
  localparam logic [7:0]  IRQCTL_RESET  = 8'h00;
  localparam logic [12:0] PC_RESET      = 13'h0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : fr_exec_pkg

/* File: src/file_register_instruction_execute.sv */
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps

// Behaviour
// - increment_file adds one, destination by d
// - copy_file moves register, one word, one cycle
// - or_accum_file ORs accumulator with register
// - store_accum writes register, flags unchanged
// - load_literal loads immediate, flags unchanged
// - interrupt_return pops, loads PC, sets enable
// - return_with_literal loads accumulator and PC
// - return pops stack, two cycles, flags kept
// - rotate left through carry, carry only
// - rotate right through carry, carry only
// - sleep clears watchdog, sets expiry, clears powerdown
// - literal minus accumulator sets carry, half-carry, zero
// - register minus accumulator, destination by d
// - xor_literal XORs immediate into accumulator
// - nibble_exchange swaps nibbles, flags untouched
// - xor_file XORs accumulator with register
// - PC change adds an idle second cycle
module file_register_instruction_execute
  import fr_exec_pkg::*;
#(
  parameter int WDT_PRESCALE = 256
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire instr_t            instr,
  input  wire logic              instr_valid,
  output logic                   instr_ready,
  input  wire logic [PC_W-1:0]   stack_head,
  output logic                   stack_pop,
  output logic [PC_W-1:0]        pc_reg,
  output logic                   osc_run,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] file_mem [0:(1<<FADDR_W)-1];
  logic [DATA_W-1:0] accum_reg;
  status_t           status_reg;
  logic [7:0]        irq_control_reg;
  logic [7:0]        watchdog_counter;
  logic [7:0]        presc_reg;
  state_t            state_reg;
  logic [11:0]       awaddr_reg;
  logic              aw_full_reg;
  logic [31:0]       wdata_reg;
  logic              wstrb0_reg;
  logic              w_full_reg;
  logic [1:0]        bresp_reg;
  logic              bvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              rvalid_reg;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic map_hit(input logic [11:0] a);
    map_hit = (a == OFF_CTRL) || (a == OFF_IRQCTL) || (a == OFF_ACCUM) ||
              (a == OFF_STATUS) || (a == OFF_PC) || (a == OFF_WDT) ||
              ((a[11:9] == OFF_FILE[11:9]) && (a[1:0] == 2'h0));
  endfunction : map_hit

  function automatic logic is_file(input logic [11:0] a);
    is_file = (a[11:9] == OFF_FILE[11:9]) && (a[1:0] == 2'h0);
  endfunction : is_file

  // ----------------------------------------------------------------
  // Execute datapath
  // ----------------------------------------------------------------
  logic              fire;
  logic [DATA_W-1:0] src_val;
  logic [DATA_W-1:0] res;
  logic [DATA_W:0]   diff;
  logic              wr_acc;
  logic              wr_file;
  logic              upd_z;
  logic              upd_c;
  logic              upd_dc;
  logic              new_c;
  logic              new_dc;
  logic              is_ret;

  assign instr_ready = ce && (state_reg == ST_EXEC);
  assign fire        = instr_valid && instr_ready;
  assign src_val     = file_mem[instr.addr];
  assign is_ret      = (instr.op == OP_RET) || (instr.op == OP_RETI) ||
                       (instr.op == OP_RETLIT);
  assign stack_pop   = fire && is_ret;
  assign osc_run     = (state_reg != ST_SLEEP);

  always_comb begin
    res    = src_val;
    diff   = '0;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    upd_z  = 1'b0;
    upd_c  = 1'b0;
    upd_dc = 1'b0;
    new_c  = status_reg.carry;
    new_dc = status_reg.hcarry;
    unique case (instr.op)
      OP_INC, OP_COPY, OP_OR, OP_XORF, OP_SUBF, OP_RLC, OP_RRC, OP_SWAP: begin
        wr_acc  = !instr.dest;
        wr_file = instr.dest;
        unique case (instr.op)
          OP_INC:  res = src_val + 8'h01;
          OP_OR:   res = accum_reg | src_val;
          OP_XORF: res = accum_reg ^ src_val;
          OP_SUBF: begin
            diff   = {1'b0, src_val} - {1'b0, accum_reg};
            res    = diff[DATA_W-1:0];
            new_c  = (accum_reg <= src_val);
            new_dc = (accum_reg[3:0] <= src_val[3:0]);
          end
          OP_RLC:  {new_c, res} = {src_val, status_reg.carry};
          OP_RRC:  {res, new_c} = {status_reg.carry, src_val};
          OP_SWAP: res = {src_val[3:0], src_val[7:4]};
          default: res = src_val;
        endcase
        upd_z  = (instr.op != OP_RLC) && (instr.op != OP_RRC) && (instr.op != OP_SWAP);
        upd_c  = (instr.op == OP_RLC) || (instr.op == OP_RRC) || (instr.op == OP_SUBF);
        upd_dc = (instr.op == OP_SUBF);
      end
      OP_STORE: begin
        res     = accum_reg;
        wr_file = 1'b1;
      end
      OP_LOADLIT, OP_RETLIT: begin
        res    = instr.lit;
        wr_acc = 1'b1;
      end
      OP_SUBLIT: begin
        diff   = {1'b0, instr.lit} - {1'b0, accum_reg};
        res    = diff[DATA_W-1:0];
        new_c  = (accum_reg <= instr.lit);
        new_dc = (accum_reg[3:0] <= instr.lit[3:0]);
        wr_acc = 1'b1;
        upd_z  = 1'b1;
        upd_c  = 1'b1;
        upd_dc = 1'b1;
      end
      OP_XORLIT: begin
        res    = accum_reg ^ instr.lit;
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      OP_IDLE, OP_RETI, OP_RET, OP_SLEEP: res = src_val;
      default: res = src_val;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  logic wr_go;
  logic wake_wr;

  assign wr_go   = ce && aw_full_reg && w_full_reg && !bvalid_reg;
  assign wake_wr = wr_go && (awaddr_reg == OFF_CTRL) && wstrb0_reg &&
                   wdata_reg[CTRL_WAKE_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_EXEC;
    end else if (ce) begin
      unique case (state_reg)
        ST_EXEC: begin
          if (fire && is_ret) begin
            state_reg <= ST_IDLE;
          end else if (fire && instr.op == OP_SLEEP) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_IDLE:  state_reg <= ST_EXEC;
        ST_SLEEP: begin
          if (wake_wr) begin
            state_reg <= ST_EXEC;
          end
        end
        default:  state_reg <= ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_reg <= PC_RESET;
    end else if (fire) begin
      if (is_ret) begin
        pc_reg <= stack_head;
      end else begin
        pc_reg <= pc_reg + 13'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accum_reg <= '0;
    end else if (fire && wr_acc) begin
      accum_reg <= res;
    end else if (wr_go && awaddr_reg == OFF_ACCUM && wstrb0_reg) begin
      accum_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (fire && wr_file) begin
      file_mem[instr.addr] <= res;
    end else if (wr_go && is_file(awaddr_reg) && wstrb0_reg) begin
      file_mem[awaddr_reg[8:2]] <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= STATUS_RESET;
    end else if (fire) begin
      if (upd_z) begin
        status_reg.zero <= (res == 8'h00);
      end
      if (upd_c) begin
        status_reg.carry <= new_c;
      end
      if (upd_dc) begin
        status_reg.hcarry <= new_dc;
      end
      if (instr.op == OP_SLEEP) begin
        status_reg.expiry <= 1'b1;
        status_reg.pdown  <= 1'b0;
      end
    end else if (wr_go && awaddr_reg == OFF_STATUS && wstrb0_reg) begin
      status_reg.zero   <= wdata_reg[2];
      status_reg.hcarry <= wdata_reg[1];
      status_reg.carry  <= wdata_reg[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_control_reg <= IRQCTL_RESET;
    end else if (fire && instr.op == OP_RETI) begin
      irq_control_reg[GIE_BIT] <= 1'b1;
    end else if (wr_go && awaddr_reg == OFF_IRQCTL && wstrb0_reg) begin
      irq_control_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg        <= PRESC_CLEAR;
      watchdog_counter <= WDT_CLEAR;
    end else if (fire && instr.op == OP_SLEEP) begin
      presc_reg        <= PRESC_CLEAR;
      watchdog_counter <= WDT_CLEAR;
    end else if (ce && state_reg != ST_SLEEP) begin
      if (presc_reg == 8'(WDT_PRESCALE - 1)) begin
        presc_reg        <= PRESC_CLEAR;
        watchdog_counter <= watchdog_counter + 8'h01;
      end else begin
        presc_reg <= presc_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = ce && !aw_full_reg;
  assign s_axi_wready  = ce && !w_full_reg;
  assign s_axi_arready = ce && !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb0_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= map_hit(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= map_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata_reg  <= '0;
        if (is_file(s_axi_araddr)) begin
          rdata_reg[7:0] <= file_mem[s_axi_araddr[8:2]];
        end else begin
          unique case (s_axi_araddr)
            OFF_CTRL:   rdata_reg[1:0]  <= {state_reg == ST_SLEEP, osc_run};
            OFF_IRQCTL: rdata_reg[7:0]  <= irq_control_reg;
            OFF_ACCUM:  rdata_reg[7:0]  <= accum_reg;
            OFF_STATUS: rdata_reg[4:0]  <= status_reg;
            OFF_PC:     rdata_reg[12:0] <= pc_reg;
            OFF_WDT:    rdata_reg[7:0]  <= watchdog_counter;
            default:    rdata_reg       <= '0;
          endcase
        end
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_ret_taken;
    fire && is_ret;
  endsequence

  sequence s_idle_then_exec;
    (state_reg == ST_IDLE && !instr_ready) ##1 (state_reg == ST_EXEC);
  endsequence

  a_inc_to_accum: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && instr.op == OP_INC && !instr.dest |=> accum_reg == $past(src_val) + 8'h01)
    else $error("increment result wrong");

  a_copy_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && instr.op == OP_COPY |=> status_reg.zero == ($past(src_val) == 8'h00))
    else $error("copy zero flag wrong");

  a_or_to_accum: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && instr.op == OP_OR && !instr.dest
    |=> accum_reg == ($past(accum_reg) | $past(src_val)))
    else $error("or result wrong");

  a_store_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && instr.op == OP_STORE |=> $stable(status_reg) && $stable(accum_reg))
    else $error("store changed flags");

  a_lit_load: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && instr.op == OP_LOADLIT
    |=> accum_reg == $past(instr.lit) && $stable(status_reg))
    else $error("literal load wrong");

  a_reti_gie: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && instr.op == OP_RETI |=> irq_control_reg[GIE_BIT] && pc_reg == $past(stack_head))
    else $error("interrupt return wrong");

  a_ret_two_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ret_taken ##1 ce |-> s_idle_then_exec)
    else $error("return not two cycles");

  a_rlc_carry: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && instr.op == OP_RLC
    |=> status_reg.carry == $past(src_val[7]) && $stable(status_reg.zero))
    else $error("rotate left carry wrong");

  a_sleep_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && instr.op == OP_SLEEP
    |=> watchdog_counter == WDT_CLEAR && status_reg.expiry && !status_reg.pdown && !osc_run)
    else $error("sleep entry wrong");

  a_sublit_carry: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && instr.op == OP_SUBLIT
    |=> status_reg.carry == ($past(accum_reg) <= $past(instr.lit)))
    else $error("subtract carry wrong");

  a_swap_nibbles: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && instr.op == OP_SWAP && !instr.dest
    |=> accum_reg == {$past(src_val[3:0]), $past(src_val[7:4])})
    else $error("nibble swap wrong");

endmodule : file_register_instruction_execute

/* File: test/ret_stack_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Return stack as seen by the core
// ----------------------------------------------------------------
module ret_stack_model
  import fr_exec_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            stack_pop,
  output logic [PC_W-1:0]      stack_head
);
  localparam logic [PC_W-1:0] SLOT [4] = '{13'h0123, 13'h0456, 13'h1ABC, 13'h0F0F};

  logic [1:0] top_reg;

  // Top entry shown until popped
  assign stack_head = SLOT[top_reg];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      top_reg <= 2'h0;
    end else if (stack_pop) begin
      top_reg <= top_reg + 2'h1;
    end
  end
endmodule : ret_stack_model

/* File: test/test_file_register_instruction_execute.sv */
`timescale 1ns/1ps

module test_file_register_instruction_execute
  import fr_exec_pkg::*;
;
  localparam logic [11:0] FILE_A = 12'h3FC;

  logic aclk, aresetn, ce, instr_valid, instr_ready, stack_pop, osc_run;
  instr_t instr;
  logic [PC_W-1:0] stack_head, pc_reg;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_mismatch;
  int compares;

  file_register_instruction_execute #(.WDT_PRESCALE(4)) u_file_register_instruction_execute (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .stack_head(stack_head), .stack_pop(stack_pop),
    .pc_reg(pc_reg), .osc_run(osc_run), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  ret_stack_model u_ret_stack_model (.aclk(aclk), .aresetn(aresetn),
    .stack_pop(stack_pop), .stack_head(stack_head));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic hang(input string what);
    n_mismatch++;
    $display("BAD %0t %s wait ran out", $time, what);
    end_sim();
  endtask : hang

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    logic at, wt, bt;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge aclk);
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      bt = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
      if (bt) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (i == 50) hang("write");
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic at, rt;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge aclk);
      at = s_axi_arvalid && s_axi_arready;
      rt = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (at) s_axi_arvalid <= 1'b0;
      if (rt) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (i == 50) hang("read");
  endtask : rd

  task automatic exec(input op_t o, input logic d, input logic [7:0] l);
    logic [PC_W-1:0] pc0, head;
    logic ret, two;
    int i;
    ret = (o == OP_RET) || (o == OP_RETI) || (o == OP_RETLIT);
    two = ret || (o == OP_SLEEP);
    @(posedge aclk);
    instr <= '{op: o, addr: 7'h7F, dest: d, lit: l};
    instr_valid <= 1'b1;
    i = 0;
    do begin
      @(negedge aclk);
      i++;
    end while (instr_ready !== 1'b1 && i < 50);
    if (i == 50) hang("instr");
    pc0 = pc_reg;
    head = stack_head;
    chk(32'(stack_pop), 32'(ret), "pop");
    @(posedge aclk);
    instr_valid <= 1'b0;
    @(negedge aclk);
    chk(32'(pc_reg), 32'(ret ? head : pc0 + 13'h1), "pc");
    chk(32'(instr_ready), 32'(!two), "ready");
  endtask : exec

  task automatic run_op(input op_t o, input logic d, input logic [7:0] a, f, s, l,
                        input logic [7:0] ea, ef, es);
    logic [31:0] v;
    logic [1:0] r;
    wr(OFF_ACCUM, 32'(a), r);
    wr(FILE_A, 32'(f), r);
    wr(OFF_STATUS, 32'(s), r);
    exec(o, d, l);
    rd(OFF_ACCUM, v, r);
    chk(v, 32'(ea), "accum");
    rd(FILE_A, v, r);
    chk(v, 32'(ef), "file");
    rd(OFF_STATUS, v, r);
    chk(v, {27'h0, 2'b11, es[2:0]}, "status");
  endtask : run_op

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] v;
    logic [1:0] r;
    rd(OFF_STATUS, v, r);
    chk(v, 32'h0000_0018, "status reset");
    rd(12'h100, v, r);
    chk({30'h0, r}, 32'(RESP_SLVERR), "unmapped read");
    wr(12'h100, 32'h0000_0055, r);
    chk({30'h0, r}, 32'(RESP_SLVERR), "unmapped write");
  endtask : t_reset

  task automatic t_moves();
    run_op(OP_LOADLIT, 1'b0, 8'h00, 8'h33, 8'h07, 8'hFF, 8'hFF, 8'h33, 8'h07);
    run_op(OP_STORE, 1'b1, 8'h4F, 8'hFF, 8'h05, 8'h00, 8'h4F, 8'h4F, 8'h05);
    run_op(OP_COPY, 1'b0, 8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04);
  endtask : t_moves

  task automatic t_logic();
    run_op(OP_INC, 1'b1, 8'h12, 8'hFF, 8'h01, 8'h00, 8'h12, 8'h00, 8'h05);
    run_op(OP_INC, 1'b0, 8'h12, 8'h7F, 8'h04, 8'h00, 8'h80, 8'h7F, 8'h00);
    run_op(OP_OR, 1'b0, 8'h0F, 8'hF0, 8'h04, 8'h00, 8'hFF, 8'hF0, 8'h00);
    run_op(OP_XORF, 1'b1, 8'h3C, 8'h3C, 8'h00, 8'h00, 8'h3C, 8'h00, 8'h04);
    run_op(OP_XORLIT, 1'b0, 8'hA5, 8'h11, 8'h00, 8'hA5, 8'h00, 8'h11, 8'h04);
  endtask : t_logic

  task automatic t_shift();
    run_op(OP_SWAP, 1'b0, 8'h00, 8'h12, 8'h07, 8'h00, 8'h21, 8'h12, 8'h07);
    run_op(OP_RLC, 1'b1, 8'h55, 8'h80, 8'h02, 8'h00, 8'h55, 8'h00, 8'h03);
    run_op(OP_RLC, 1'b0, 8'h55, 8'h41, 8'h01, 8'h00, 8'h83, 8'h41, 8'h00);
    run_op(OP_RRC, 1'b0, 8'h55, 8'h01, 8'h04, 8'h00, 8'h00, 8'h01, 8'h05);
    run_op(OP_RRC, 1'b1, 8'h55, 8'h82, 8'h01, 8'h00, 8'h55, 8'hC1, 8'h00);
  endtask : t_shift

  task automatic t_sub();
    run_op(OP_SUBLIT, 1'b0, 8'h11, 8'h00, 8'h07, 8'h10, 8'hFF, 8'h00, 8'h00);
    run_op(OP_SUBLIT, 1'b0, 8'h25, 8'h00, 8'h00, 8'h25, 8'h00, 8'h00, 8'h07);
    run_op(OP_SUBF, 1'b1, 8'h01, 8'h20, 8'h04, 8'h00, 8'h01, 8'h1F, 8'h01);
    run_op(OP_SUBF, 1'b0, 8'h08, 8'h13, 8'h00, 8'h00, 8'h0B, 8'h13, 8'h01);
  endtask : t_sub

  task automatic t_returns();
    logic [31:0] v;
    logic [1:0] r;
    wr(OFF_IRQCTL, 32'h0, r);
    exec(OP_RETI, 1'b0, 8'h00);
    rd(OFF_IRQCTL, v, r);
    chk({24'h0, v[7:0]}, 32'h0000_0080, "irq enable");
    run_op(OP_RETLIT, 1'b0, 8'h01, 8'h09, 8'h07, 8'h77, 8'h77, 8'h09, 8'h07);
    run_op(OP_RET, 1'b0, 8'h01, 8'h09, 8'h02, 8'h00, 8'h01, 8'h09, 8'h02);
  endtask : t_returns

  task automatic t_sleep();
    logic [31:0] v;
    logic [1:0] r;
    exec(OP_SLEEP, 1'b0, 8'h00);
    chk(32'(osc_run), 32'h0, "osc stopped");
    rd(OFF_WDT, v, r);
    chk(v, 32'(WDT_CLEAR), "watchdog");
    rd(OFF_STATUS, v, r);
    chk({30'h0, v[4:3]}, 32'h2, "expiry pdown");
    wr(OFF_CTRL, 32'h1, r);
    @(negedge aclk);
    chk(32'(osc_run), 32'h1, "woken");
  endtask : t_sleep

  // ----------------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    n_mismatch = 0;
    compares = 0;
    aresetn = 1'b0;
    ce = 1'b1;
    instr = '{op: OP_IDLE, addr: 7'h00, dest: 1'b0, lit: 8'h00};
    instr_valid = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_moves();
    t_logic();
    t_shift();
    t_sub();
    t_returns();
    t_sleep();
    end_sim();
  end
endmodule : test_file_register_instruction_execute
